/* File: core/gpio_ext_irq_map.vh */
// register offsets, field positions and reset values of the gpio irq block
`ifndef GPIO_EXT_IRQ_MAP_VH
`define GPIO_EXT_IRQ_MAP_VH
// register byte offsets
`define OFS_GPIO_DIR      12'h000
`define OFS_GPIO_OUT      12'h004
`define OFS_GPIO_IN       12'h008
`define OFS_IRQ_ENABLE    12'h00c
`define OFS_IRQ_POLARITY  12'h010
`define OFS_IRQ_STATUS    12'h014
`define OFS_IRQ_MASK      12'h018
`define OFS_PCI_MODE      12'h01c
// field positions
`define IRQ_ENABLE_LSB    4
`define IRQ_ENABLE_MSB    7
`define POLARITY_LSB      0
`define POLARITY_MSB      3
`define STATUS_NMI_BIT    4
// reset values
`define RST_GPIO_DIR      16'h0000
`define RST_GPIO_OUT      16'h0000
`define RST_IRQ_ENABLE    8'h00
`define RST_IRQ_POLARITY  4'h0
`define RST_IRQ_MASK      5'h00
`define RST_PCI_MODE      1'h0
`endif

/* File: core/edge_detect.v */
// synchroniser and edge detector bank for the interrupt inputs
`timescale 1ns/100ps
module edge_detect #(
    parameter WIDTH = 5
) (
    // clock and reset
    input  wire             pclk,
    input  wire             presetn,
    input  wire             clk_en,
    // pins and edge selection
    input  wire [WIDTH-1:0] pin_in,
    input  wire [WIDTH-1:0] fall_sel,
    // results
    output reg  [WIDTH-1:0] sync_q,
    output reg  [WIDTH-1:0] edge_q
);
    reg [WIDTH-1:0] meta_q;
    reg [WIDTH-1:0] prev_q;
    // two-stage sync, then compare with previous sample
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            meta_q <= {WIDTH{1'b0}};
            sync_q <= {WIDTH{1'b0}};
            prev_q <= {WIDTH{1'b0}};
            edge_q <= {WIDTH{1'b0}};
        end else if (clk_en) begin
            meta_q <= pin_in;
            sync_q <= meta_q;
            prev_q <= sync_q;
            // one bit per input picks rising or falling edge
            edge_q <= (sync_q & ~prev_q & ~fall_sel)
                    | (~sync_q & prev_q & fall_sel);
        end
    end
endmodule // edge_detect

/* File: core/gpio_ext_irq_pins.v */
// gpio pins with external interrupts, nmi and pci-shared pins, apb slave
//******************************************************************
//******************************************************************
`timescale 1ns/100ps
`include "gpio_ext_irq_map.vh"
module gpio_ext_irq_pins #(
    parameter NPIN = 16
) (
    // apb
    input  wire            pclk,
    input  wire            presetn,
    input  wire            clk_en,
    input  wire            psel,
    input  wire            penable,
    input  wire            pwrite,
    input  wire [11:0]     paddr,
    input  wire [31:0]     pwdata,
    output reg  [31:0]     prdata,
    output reg             pready,
    output reg             pslverr,
    // pins
    input  wire [NPIN-1:0] gpio_in,
    output reg  [NPIN-1:0] gpio_out,
    output reg  [NPIN-1:0] gpio_oe,
    input  wire            nmi_in,
    // pci sideband towards internal logic
    input  wire            pci_inta_req,
    input  wire            pci_request_req,
    output reg             pci_shared_reset_in,
    output reg             pci_shared_clock_in,
    output reg             pci_shared_grant_in,
    // interrupts
    output reg             nmi_pulse,
    output reg             irq
);
    //******************************************************************
    // registers
    //******************************************************************
    reg [15:0] dir_q;
    reg [15:0] out_q;
    reg [7:0]  irq_enable_bits;
    reg [3:0]  ext_irq_polarity_bits;
    reg [4:0]  status_q;
    reg [4:0]  mask_q;
    reg        pci_mode_q;
    wire [4:0]  edge_w;
    reg  [15:0] in_sync_q;
    reg  [15:0] in_meta_q;
    wire        wr_en;
    wire        rd_en;
    wire [4:0]  ev_w;
    wire        rd_stat;

    // sync upper irq pins and nmi; nmi is always rising edge
    edge_detect #(
        .WIDTH (5)
    ) u_edge (
        .pclk     (pclk),
        .presetn  (presetn),
        .clk_en   (clk_en),
        .pin_in   ({nmi_in, gpio_in[7:4]}),
        .fall_sel ({1'b0, ext_irq_polarity_bits}),
        .sync_q   (),
        .edge_q   (edge_w)
    );
    assign wr_en   = psel & penable & pwrite & clk_en;
    assign rd_en   = psel & penable & ~pwrite & clk_en;
    assign rd_stat = rd_en & (paddr == `OFS_IRQ_STATUS);
    // external events count only when enabled; nmi always
    assign ev_w = {edge_w[4],
                   edge_w[3:0] & irq_enable_bits[7:4]};

    // gpio input sync for readback
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            in_meta_q <= 16'h0000;
            in_sync_q <= 16'h0000;
        end else if (clk_en) begin
            in_meta_q <= gpio_in;
            in_sync_q <= in_meta_q;
        end
    end

    // register writes, sticky status with set beating clear-on-read
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            dir_q                 <= `RST_GPIO_DIR;
            out_q                 <= `RST_GPIO_OUT;
            irq_enable_bits       <= `RST_IRQ_ENABLE;
            ext_irq_polarity_bits <= `RST_IRQ_POLARITY;
            mask_q                <= `RST_IRQ_MASK;
            pci_mode_q            <= `RST_PCI_MODE;
            status_q              <= 5'h00;
        end else if (clk_en) begin
            status_q <= (rd_stat ? 5'h00 : status_q) | ev_w;
            if (wr_en) begin
                if (paddr == `OFS_GPIO_DIR) begin
                    dir_q <= pwdata[15:0];
                end else if (paddr == `OFS_GPIO_OUT) begin
                    out_q <= pwdata[15:0];
                end else if (paddr == `OFS_IRQ_ENABLE) begin
                    irq_enable_bits <= pwdata[7:0];
                end else if (paddr == `OFS_IRQ_POLARITY) begin
                    ext_irq_polarity_bits <= pwdata[3:0];
                end else if (paddr == `OFS_IRQ_MASK) begin
                    mask_q <= pwdata[4:0];
                end else if (paddr == `OFS_PCI_MODE) begin
                    pci_mode_q <= pwdata[0];
                end
            end
        end
    end

    // apb answer: zero wait state, error on address above OFS_PCI_MODE
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata  <= 32'h00000000;
            pready  <= 1'b0;
            pslverr <= 1'b0;
        end else if (clk_en) begin
            pready  <= psel & ~penable;
            pslverr <= psel & ~penable & (paddr > `OFS_PCI_MODE);
            prdata  <= 32'h00000000;
            if (psel & ~penable & ~pwrite) begin
                if (paddr == `OFS_GPIO_DIR) begin
                    prdata <= {16'h0000, dir_q};
                end else if (paddr == `OFS_GPIO_OUT) begin
                    prdata <= {16'h0000, out_q};
                end else if (paddr == `OFS_GPIO_IN) begin
                    prdata <= {16'h0000, in_sync_q};
                end else if (paddr == `OFS_IRQ_ENABLE) begin
                    prdata <= {24'h000000, irq_enable_bits};
                end else if (paddr == `OFS_IRQ_POLARITY) begin
                    prdata <= {28'h0000000, ext_irq_polarity_bits};
                end else if (paddr == `OFS_IRQ_STATUS) begin
                    prdata <= {27'h0000000, status_q | ev_w};
                end else if (paddr == `OFS_IRQ_MASK) begin
                    prdata <= {27'h0000000, mask_q};
                end else if (paddr == `OFS_PCI_MODE) begin
                    prdata <= {31'h00000000, pci_mode_q};
                end
            end
        end
    end

    // pin drivers and pci sideband routing
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            gpio_out            <= 16'h0000;
            gpio_oe             <= 16'h0000;
            pci_shared_reset_in <= 1'b0;
            pci_shared_clock_in <= 1'b0;
            pci_shared_grant_in <= 1'b0;
            nmi_pulse           <= 1'b0;
            irq                 <= 1'b0;
        end else if (clk_en) begin
            gpio_out <= out_q;
            // irq-enabled pins never drive
            gpio_oe  <= dir_q & ~{8'h00, irq_enable_bits[7:4], 4'h0};
            if (pci_mode_q) begin
                // pins 15, 14, 12 input only; 13, 11 driven low when asserted
                gpio_oe[15] <= 1'b0;
                gpio_oe[14] <= 1'b0;
                gpio_oe[12] <= 1'b0;
                gpio_out[13] <= 1'b0;
                gpio_oe[13]  <= pci_inta_req;
                gpio_out[11] <= 1'b0;
                gpio_oe[11]  <= pci_request_req;
            end
            pci_shared_reset_in <= pci_mode_q & in_sync_q[15];
            pci_shared_clock_in <= pci_mode_q & in_sync_q[14];
            pci_shared_grant_in <= pci_mode_q & in_sync_q[12];
            nmi_pulse <= edge_w[4];
            irq <= |((status_q | ev_w) & mask_q);
        end
    end
endmodule // gpio_ext_irq_pins

/* File: dv/board_pins_model.sv */
// board logic on the far side of the gpio pins
`timescale 1ns/100ps
module board_pins_model (
    input  wire logic [15:0] gpio_out,
    input  wire logic [15:0] gpio_oe,
    input  wire logic [15:0] board_drv,
    output logic      [15:0] pin_lvl
);
    // the board yields each pin that the device drives
    always_comb begin
        for (int i = 0; i < 16; i++) begin
            pin_lvl[i] = gpio_oe[i] ? gpio_out[i] : board_drv[i];
        end
    end
endmodule // board_pins_model

/* File: dv/gpio_ext_irq_pins_props.sv */
// assertions on the ports of the gpio irq block
`timescale 1ns/100ps
module gpio_ext_irq_pins_props (
    input wire logic        pclk,
    input wire logic        presetn,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic [11:0] paddr,
    input wire logic        pready,
    input wire logic        pslverr,
    input wire logic [15:0] gpio_out,
    input wire logic [15:0] gpio_oe,
    input wire logic        nmi_in,
    input wire logic        pci_inta_req,
    input wire logic        pci_shared_reset_in,
    input wire logic        pci_shared_clock_in,
    input wire logic        pci_shared_grant_in,
    input wire logic        nmi_pulse,
    input wire logic        irq
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    setup_answer_a: assert property (psel && !penable |=> pready)
        else $error("no answer after setup");
    ready_pulse_a: assert property (pready |=> !pready)
        else $error("ready held too long");
    bad_addr_a: assert property (pslverr |-> pready && paddr > 12'h01c)
        else $error("error on mapped address");
    reset_quiet_a: assert property ($rose(presetn) |-> gpio_oe == 16'h0000 && !irq && !nmi_pulse)
        else $error("outputs not quiet after reset");
    nmi_single_a: assert property (nmi_pulse |=> !nmi_pulse)
        else $error("nmi pulse too long");
    nmi_cause_a: assert property (nmi_pulse |-> $past(nmi_in, 4) && !$past(nmi_in, 5))
        else $error("nmi without high input");
    nmi_rise_a: assert property ($rose(nmi_in) |-> ##[1:6] nmi_pulse)
        else $error("nmi edge missed");
    pci_input_a: assert property (pci_shared_reset_in || pci_shared_clock_in
        || pci_shared_grant_in |-> gpio_oe[15:14] == 2'b00 && !gpio_oe[12])
        else $error("pci input pin driven");
    inta_drive_a: assert property (pci_shared_grant_in && $past(pci_inta_req)
        |-> gpio_oe[13] && !gpio_out[13])
        else $error("inta not driven low");
    cover property (nmi_pulse);
    cover property (irq);
    cover property (pslverr);
endmodule // gpio_ext_irq_pins_props
bind gpio_ext_irq_pins gpio_ext_irq_pins_props u_props (.pclk(pclk),
    .presetn(presetn), .psel(psel), .penable(penable), .paddr(paddr),
    .pready(pready), .pslverr(pslverr), .gpio_out(gpio_out),
    .gpio_oe(gpio_oe), .nmi_in(nmi_in), .pci_inta_req(pci_inta_req),
    .pci_shared_reset_in(pci_shared_reset_in), .irq(irq),
    .pci_shared_clock_in(pci_shared_clock_in), .nmi_pulse(nmi_pulse),
    .pci_shared_grant_in(pci_shared_grant_in));

/* File: dv/gpio_ext_irq_pins_tb_top.sv */
// self-checking bench of the gpio irq block
`timescale 1ns/100ps
module gpio_ext_irq_pins_tb_top;
    logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
    logic [11:0] paddr = 0;
    logic [31:0] pwdata = 0, prdata, rd;
    logic pready, pslverr, er, nmi_in = 0, inta_q = 0, req_q = 0;
    logic [15:0] gpio_out, gpio_oe, pins, drv = 0;
    logic rst_in, clk_in, gnt_in, nmi_pulse, irq;
    integer fail_count = 0, tests_run = 0, cnt;
    always #20 pclk = ~pclk;
    gpio_ext_irq_pins u_dut (.pclk(pclk), .presetn(presetn), .clk_en(1'b1),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .gpio_in(pins), .gpio_out(gpio_out),
        .gpio_oe(gpio_oe), .nmi_in(nmi_in), .pci_inta_req(inta_q),
        .pci_request_req(req_q), .pci_shared_reset_in(rst_in),
        .pci_shared_clock_in(clk_in), .pci_shared_grant_in(gnt_in),
        .nmi_pulse(nmi_pulse), .irq(irq));
    board_pins_model u_board (.gpio_out(gpio_out), .gpio_oe(gpio_oe),
        .board_drv(drv), .pin_lvl(pins));
    task report_and_stop;
        $display("checks %0d mismatches %0d", tests_run, fail_count);
        if (fail_count == 0 && tests_run > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask
    task chk(input logic [31:0] seen, exp, input string what);
        tests_run++;
        if (seen !== exp) begin
            fail_count++;
            $display("CHECK FAILED %s exp %h seen %h", what, exp, seen);
        end
    endtask
    task cyc(input integer k);
        repeat (k) @(posedge pclk);
    endtask
    // one apb transfer, held until pready is sampled high
    task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        integer n;
        @(posedge pclk);
        psel <= 1; pwrite <= w; paddr <= a; pwdata <= d;
        @(posedge pclk);
        penable <= 1;
        n = 0;
        do begin @(posedge pclk); n++; end while (pready !== 1'b1 && n < 20);
        if (n >= 20) begin fail_count++; report_and_stop(); end
        rd = prdata; er = pslverr;
        psel <= 0; penable <= 0;
    endtask
    task t_gpio;
        chk(gpio_oe, 0, "oe at reset");
        apb(0, 12'h000, 0); chk(rd, 0, "dir at reset");
        apb(1, 12'h000, 32'hffff); apb(1, 12'h004, 32'ha5a5); cyc(4);
        chk({gpio_oe, gpio_out}, 32'hffffa5a5, "pin drive");
        apb(0, 12'h008, 0); chk(rd, 32'ha5a5, "pin read");
        apb(1, 12'h000, 0); apb(0, 12'h020, 0); chk(er, 1, "unmapped");
        $display("test gpio done");
    endtask
    task t_ext;
        apb(1, 12'h018, 32'h1f); apb(1, 12'h010, 32'h2);
        apb(1, 12'h00c, 32'hf0); apb(1, 12'h000, 32'hf0); cyc(2);
        chk(gpio_oe[7:4], 0, "irq pins input");
        drv[7:4] <= 4'b0010; cyc(8); apb(0, 12'h014, 0);
        chk(rd, 0, "wrong edge");
        drv[7:4] <= 4'b1101; cyc(8); chk(irq, 1, "irq level");
        apb(0, 12'h014, 0); chk(rd, 32'hf, "edge status");
        apb(0, 12'h014, 0); chk(rd, 0, "no level retrigger");
        cyc(2); chk(irq, 0, "irq cleared");
        $display("test ext irq done");
    endtask
    task t_nmi;
        cnt = 0; nmi_in <= 1;
        repeat (16) begin @(posedge pclk); cnt += nmi_pulse; if (cnt == 1 && nmi_in) nmi_in <= 0; end
        chk(cnt, 1, "nmi pulses");
        apb(0, 12'h014, 0); chk(rd, 32'h10, "nmi status");
        $display("test nmi done");
    endtask
    task t_pci;
        apb(1, 12'h01c, 1); apb(1, 12'h000, 32'hffff);
        drv[15:11] <= 5'b11010; inta_q <= 1; cyc(6);
        chk({rst_in, clk_in, gnt_in}, 3'b111, "pci inputs");
        chk({gpio_oe[15:12], gpio_out[13]}, 5'b00100, "pci oe");
        inta_q <= 0; req_q <= 1; cyc(4);
        chk({gpio_oe[11], gpio_out[11]}, 2'b10, "request out");
        presetn <= 0; cyc(2);
        chk({gpio_oe, rst_in, gnt_in}, 0, "mid reset");
        presetn <= 1; apb(0, 12'h014, 0); chk(rd, 0, "pending cleared");
        $display("test pci and reset done");
    endtask
    initial begin
        cyc(12); presetn <= 1;
        t_gpio(); t_ext(); t_nmi(); t_pci();
        report_and_stop();
    end
endmodule // gpio_ext_irq_pins_tb_top
